// file: hdl/pmx_top.sv
`timescale 1ns/1ps
module pmx_top #(
   parameter int CLK_HZ = 25_000_000
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Device pins, inputs
   input wire logic eeprom_data_io_i,
   input wire logic reset_in_n,
   input wire logic chip_select_n,
   input wire logic write_strobe_n,
   input wire logic read_strobe_n,
   // Device pins, outputs
   output logic eeprom_data_io_o,
   output logic eeprom_data_io_oe,
   output logic eeprom_select_n,
   output logic eeprom_serial_clock,
   output logic wake_indicator_o,
   output logic wake_indicator_oe,
   // Internal MII signals to monitor
   input wire logic mii_tx_en,
   input wire logic mii_tx_clk,
   input wire logic mii_rx_dv,
   input wire logic mii_rx_clk,
   // Pin role configuration
   input wire pmx_pkg::pmx_data_mode_t data_mode,
   input wire pmx_pkg::pmx_clk_mode_t clk_mode,
   input wire logic gp_output_three,
   input wire logic gp_output_four,
   // Serial EEPROM controller
   input wire pmx_pkg::pmx_ee_ctl_t ee_ctl,
   output logic ee_din,
   // Power management
   input wire logic pm_sleep,
   input wire pmx_pkg::pmx_wake_cfg_t wake_cfg,
   input wire logic pme_event,
   input wire logic pme_clear,
   output logic wake_pending,
   output logic wake_req,
   // System status
   output logic sys_reset_n,
   output logic bus_width_strap,
   output logic strap_valid,
   // Host write gating
   output logic host_read_seen,
   output logic host_write_ok,
   output logic host_write_drop
);
   import pmx_pkg::*;

   if (CLK_HZ != PMX_CLK_HZ)
   begin : g_clk_chk
      $error("pmx_top is built for a 25 MHz reference clock only");
   end

   typedef struct packed {
      logic [PMX_POR_W-1:0] por_cnt;
      logic sys_rst;
      logic strap_done;
      logic bus32;
      logic read_seen;
      logic rd_q;
      logic wr_q;
      logic write_ok;
      logic write_drop;
      logic wake;
      logic ee_cs_n;
      logic ee_clk;
      logic d_o;
      logic d_oe;
      logic din;
   } pmx_top_st_t;

   localparam pmx_top_st_t PMX_TOP_RST = '{
      por_cnt: PMX_POR_RST,
      sys_rst: 1'b1,
      strap_done: 1'b0,
      bus32: PMX_BUS32_RST,
      read_seen: 1'b0,
      rd_q: 1'b0,
      wr_q: 1'b0,
      write_ok: 1'b0,
      write_drop: 1'b0,
      wake: 1'b0,
      ee_cs_n: 1'b1,
      ee_clk: 1'b0,
      d_o: 1'b0,
      d_oe: 1'b0,
      din: 1'b0
   };

   pmx_top_st_t state_q;
   pmx_top_st_t state_d;
   pmx_pins_t pins_raw;
   pmx_pins_t pins_s;
   logic rst_now;
   logic rd_act;
   logic wr_act;
   logic rd_rise;
   logic wr_rise;
   logic ee_both;

   // Every off-domain input crosses two flops; the MII clocks are sampled, so
   // a monitored clock is only a coarse, aliased copy at this rate
   assign pins_raw = '{
      eeprom_data_i: eeprom_data_io_i,
      reset_in_n: reset_in_n,
      chip_select_n: chip_select_n,
      write_strobe_n: write_strobe_n,
      read_strobe_n: read_strobe_n,
      tx_en: mii_tx_en,
      tx_clk: mii_tx_clk,
      rx_dv: mii_rx_dv,
      rx_clk: mii_rx_clk
   };

   pmx_sync #(
      .W(PMX_PINS_W),
      .RST_VAL(PMX_PINS_IDLE)
   ) u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d(pins_raw),
      .q(pins_s)
   );

   // Host cycle qualification, chip select with each strobe
   assign rd_act = !pins_s.chip_select_n && !pins_s.read_strobe_n;
   assign wr_act = !pins_s.chip_select_n && !pins_s.write_strobe_n;
   assign rd_rise = rd_act && !state_q.rd_q;
   assign wr_rise = wr_act && !state_q.wr_q;
   assign ee_both = (data_mode == PMX_D_EEPROM) && (clk_mode == PMX_C_EEPROM);

   always_comb
   begin
      state_d = state_q;

      // power-on stretch, then follow the pulled-up reset pin
      if (state_q.por_cnt != PMX_POR_LAST)
      begin
         state_d.por_cnt = state_q.por_cnt + 1'b1;
      end
      // any reset source holds the internal reset
      rst_now = (state_q.por_cnt != PMX_POR_LAST) || !pins_s.reset_in_n;
      state_d.sys_rst = rst_now;

      // strap taken on the first cycle out of reset
      if (state_q.sys_rst && !rst_now)
      begin
         state_d.bus32 = pins_s.eeprom_data_i;
         state_d.strap_done = 1'b1;
      end
      else if (rst_now)
      begin
         state_d.strap_done = 1'b0;
      end

      // Strobe history for edge detection
      state_d.rd_q = rd_act;
      state_d.wr_q = wr_act;

      // first read arms writes; sleep disarms, so a read is needed again
      state_d.read_seen = (rd_rise && !pm_sleep) || (state_q.read_seen && !pm_sleep);
      state_d.write_ok = wr_rise && state_q.read_seen && !pm_sleep;
      // an unarmed write only raises a flag, nothing downstream sees it
      state_d.write_drop = wr_rise && !state_q.read_seen && !pm_sleep;
      // any qualified write wakes a sleeping device, data is not looked at
      state_d.wake = wr_rise && pm_sleep;

      // data pin follows the EEPROM controller in EEPROM role
      unique case (data_mode)
         PMX_D_EEPROM:
         begin
            state_d.d_o = ee_ctl.dout;
            state_d.d_oe = ee_ctl.doe;
         end
         PMX_D_GPO:
         begin
            state_d.d_o = gp_output_three;
            state_d.d_oe = 1'b1;
         end
         PMX_D_TX_EN:
         begin
            state_d.d_o = pins_s.tx_en;
            state_d.d_oe = 1'b1;
         end
         PMX_D_TX_CLK:
         begin
            state_d.d_o = pins_s.tx_clk;
            state_d.d_oe = 1'b1;
         end
      endcase

      unique case (clk_mode)
         PMX_C_EEPROM: state_d.ee_clk = ee_ctl.sclk;
         PMX_C_GPO: state_d.ee_clk = gp_output_four;
         PMX_C_RX_DV: state_d.ee_clk = pins_s.rx_dv;
         PMX_C_RX_CLK: state_d.ee_clk = pins_s.rx_clk;
      endcase

      // select held idle if either pin is repurposed
      state_d.ee_cs_n = !(ee_ctl.cs && ee_both);

      // outside the bus width strap, pin level reaches logic only as EEPROM serial data
      state_d.din = (data_mode == PMX_D_EEPROM) ? pins_s.eeprom_data_i : 1'b0;

      // internal reset parks every pin and pulse; the data pin floats so
      // the strap level is readable at release
      if (rst_now)
      begin
         state_d.read_seen = 1'b0;
         state_d.write_ok = 1'b0;
         state_d.write_drop = 1'b0;
         state_d.wake = 1'b0;
         state_d.ee_cs_n = 1'b1;
         state_d.ee_clk = 1'b0;
         state_d.d_o = 1'b0;
         state_d.d_oe = 1'b0;
         state_d.din = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         state_q <= PMX_TOP_RST;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // wake indicator; it has no path to the wake request
   pmx_wake u_wake (
      .clk(clk),
      .rst_b(rst_b),
      .soft_rst(state_q.sys_rst),
      .cfg(wake_cfg),
      .pme_event(pme_event),
      .pme_clear(pme_clear),
      .wake_indicator_o(wake_indicator_o),
      .wake_indicator_oe(wake_indicator_oe),
      .wake_pending(wake_pending)
   );

   // Outputs straight from the state register
   assign eeprom_data_io_o = state_q.d_o;
   assign eeprom_data_io_oe = state_q.d_oe;
   assign eeprom_select_n = state_q.ee_cs_n;
   assign eeprom_serial_clock = state_q.ee_clk;
   assign ee_din = state_q.din;
   assign wake_req = state_q.wake;
   assign sys_reset_n = !state_q.sys_rst;
   assign bus_width_strap = state_q.bus32;
   assign strap_valid = state_q.strap_done;
   assign host_read_seen = state_q.read_seen;
   assign host_write_ok = state_q.write_ok;
   assign host_write_drop = state_q.write_drop;

   // Checks on the pin mux, reset and host gating
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_select_data_idle: assert property (
      (data_mode != PMX_D_EEPROM) |=> eeprom_select_n)
      else $error("chip select active while data pin repurposed");
   a_select_clk_idle: assert property (
      (clk_mode != PMX_C_EEPROM) |=> eeprom_select_n)
      else $error("chip select active while clock pin repurposed");
   a_data_gpo_drive: assert property (
      (data_mode == PMX_D_GPO && sys_reset_n && pins_s.reset_in_n)
      |=> eeprom_data_io_oe && (eeprom_data_io_o == $past(gp_output_three)))
      else $error("data pin does not carry the general output");
   a_data_txen_mon: assert property (
      (data_mode == PMX_D_TX_EN && sys_reset_n && pins_s.reset_in_n)
      |=> eeprom_data_io_o == $past(pins_s.tx_en))
      else $error("data pin does not monitor transmit enable");
   a_clk_rx_mon: assert property (
      (clk_mode == PMX_C_RX_CLK && sys_reset_n && pins_s.reset_in_n)
      |=> eeprom_serial_clock == $past(pins_s.rx_clk))
      else $error("clock pin does not monitor receive clock");
   a_clk_gpo_drive: assert property (
      (clk_mode == PMX_C_GPO && sys_reset_n && pins_s.reset_in_n)
      |=> eeprom_serial_clock == $past(gp_output_four))
      else $error("clock pin does not carry the general output");
   a_ee_passthru: assert property (
      (ee_both && sys_reset_n && pins_s.reset_in_n)
      |=> (eeprom_select_n == !$past(ee_ctl.cs))
          && (eeprom_data_io_oe == $past(ee_ctl.doe)))
      else $error("EEPROM mode does not follow the controller");
   a_no_gp_input: assert property (
      (data_mode != PMX_D_EEPROM) |=> !ee_din)
      else $error("repurposed data pin leaks as input");
   a_strap_latch: assert property (
      $rose(strap_valid) |-> bus_width_strap == $past(pins_s.eeprom_data_i))
      else $error("bus width strap not taken at release");
   a_strap_floats: assert property (
      !sys_reset_n |-> !eeprom_data_io_oe)
      else $error("data pin driven during reset");
   a_reset_pin_hold: assert property (
      !pins_s.reset_in_n |=> !sys_reset_n && eeprom_select_n && !host_write_ok)
      else $error("reset pin does not hold the device in reset");
   a_por_stretch: assert property (
      (state_q.por_cnt != PMX_POR_LAST) |=> !sys_reset_n)
      else $error("released before power-on reset expired");
   a_write_gated: assert property (
      (wr_rise && !host_read_seen && !pm_sleep && sys_reset_n && pins_s.reset_in_n)
      |=> host_write_drop && !host_write_ok)
      else $error("write acted on before first read");
   a_write_passes: assert property (
      (wr_rise && host_read_seen && !pm_sleep && pins_s.reset_in_n)
      |=> host_write_ok && !host_write_drop)
      else $error("armed write not passed");
   a_drop_quiet: assert property (
      host_write_drop |-> !host_write_ok && !wake_req)
      else $error("discarded write had a side effect");
   a_sleep_rearm: assert property (
      pm_sleep |=> !host_read_seen)
      else $error("read arming survived a power-saving state");
   a_wake_on_write: assert property (
      (wr_rise && pm_sleep && pins_s.reset_in_n) |=> wake_req ##1 !wake_req)
      else $error("sleeping device missed the wake write");
   a_wake_cause: assert property (
      wake_req |-> $past(wr_rise) && $past(pm_sleep))
      else $error("wake without a host write cycle");

   c_strap_wide: cover property ($rose(strap_valid) && bus_width_strap);
   c_write_drop: cover property (host_write_drop ##[1:50] host_write_ok);
   c_wake_seq: cover property (wake_pending ##[1:50] wake_req);
   c_tx_mon: cover property (data_mode == PMX_D_TX_CLK && eeprom_data_io_o ##1 !eeprom_data_io_o);
endmodule

// file: hdl/pmx_pkg.sv
package pmx_pkg;

   // Reference clock
   localparam int PMX_CLK_HZ = 25_000_000;
   localparam int PMX_CLK_MHZ = 25;

   // Internal power-on reset stretch, time in ns and derived cycle count (rounded up)
   localparam int PMX_POR_NS = 10_000;
   localparam int PMX_POR_CYCLES = (PMX_POR_NS * PMX_CLK_MHZ + 999) / 1000;
   localparam int PMX_POR_W = $clog2(PMX_POR_CYCLES + 1);
   localparam logic [PMX_POR_W-1:0] PMX_POR_LAST = PMX_POR_W'(PMX_POR_CYCLES);
   localparam logic [PMX_POR_W-1:0] PMX_POR_RST = '0;

   // Reset value of the latched bus width (low selects the 16-bit bus)
   localparam logic PMX_BUS32_RST = 1'b0;

   // Role of the EEPROM data pin
   typedef enum logic [1:0] {
      PMX_D_EEPROM = 2'b00,
      PMX_D_GPO = 2'b01,
      PMX_D_TX_EN = 2'b10,
      PMX_D_TX_CLK = 2'b11
   } pmx_data_mode_t;

   // Role of the EEPROM clock pin
   typedef enum logic [1:0] {
      PMX_C_EEPROM = 2'b00,
      PMX_C_GPO = 2'b01,
      PMX_C_RX_DV = 2'b10,
      PMX_C_RX_CLK = 2'b11
   } pmx_clk_mode_t;

   // Inputs from outside the clock domain, synchronised as one bundle
   typedef struct packed {
      logic eeprom_data_i;
      logic reset_in_n;
      logic chip_select_n;
      logic write_strobe_n;
      logic read_strobe_n;
      logic tx_en;
      logic tx_clk;
      logic rx_dv;
      logic rx_clk;
   } pmx_pins_t;

   localparam int PMX_PINS_W = $bits(pmx_pins_t);
   localparam pmx_pins_t PMX_PINS_IDLE = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

   // Drive requests from the serial EEPROM controller
   typedef struct packed {
      logic cs;
      logic sclk;
      logic dout;
      logic doe;
   } pmx_ee_ctl_t;

   // Wake indicator configuration from software
   typedef struct packed {
      logic enable;
      logic active_high;
      logic open_drain;
   } pmx_wake_cfg_t;

endpackage

// file: hdl/pmx_sync.sv
`timescale 1ns/1ps
module pmx_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } pmx_sync_st_t;

   pmx_sync_st_t state_q;
   pmx_sync_st_t state_d;

   if (W < 1)
   begin : g_chk
      $error("pmx_sync width must be at least one");
   end

   // First stage feeds only the second stage
   always_comb
   begin
      state_d.s1 = d;
      state_d.s2 = state_q.s1;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         state_q <= {RST_VAL, RST_VAL};
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign q = state_q.s2;
endmodule

// file: hdl/pmx_wake.sv
`timescale 1ns/1ps
module pmx_wake (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic soft_rst,
   // Events and configuration
   input wire pmx_pkg::pmx_wake_cfg_t cfg,
   input wire logic pme_event,
   input wire logic pme_clear,
   // Pin and pending status
   output logic wake_indicator_o,
   output logic wake_indicator_oe,
   output logic wake_pending
);
   import pmx_pkg::*;

   typedef struct packed {
      logic pending;
      logic pin_o;
      logic pin_oe;
   } pmx_wake_st_t;

   pmx_wake_st_t state_q;
   pmx_wake_st_t state_d;
   logic level;

   always_comb
   begin
      state_d = state_q;
      // sticky wake request, set beats clear
      state_d.pending = (cfg.enable && pme_event) || (state_q.pending && !pme_clear);
      if (soft_rst)
      begin
         state_d.pending = 1'b0;
      end
      level = state_d.pending ? cfg.active_high : !cfg.active_high;
      state_d.pin_o = cfg.open_drain ? 1'b0 : level;
      state_d.pin_oe = cfg.open_drain ? !level : 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         state_q <= '{1'b0, 1'b0, 1'b0};
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign wake_indicator_o = state_q.pin_o;
   assign wake_indicator_oe = state_q.pin_oe;
   assign wake_pending = state_q.pending;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_wake_event_sets: assert property (
      (cfg.enable && pme_event && !soft_rst) |=> wake_pending)
      else $error("wake event did not set the wake request");
   a_wake_pp_level: assert property (
      (!cfg.open_drain && $stable(cfg)) ##1 (!cfg.open_drain && $stable(cfg))
      |-> wake_indicator_oe && (wake_indicator_o == (wake_pending == cfg.active_high)))
      else $error("push-pull wake level wrong");
endmodule

// file: bench/pmx_host.sv
`timescale 1ns/1ps
module pmx_host (
   // Clock
   input wire logic clk,
   // Host strobes, active low
   output logic cs_n,
   output logic wr_n,
   output logic rd_n
);
   initial
   begin
      {cs_n, wr_n, rd_n} = 3'h7;
   end

   // host access order
   // The bench issues its first write before any read, so that write is dropped. The model has no address lines,
   // so every wake write counts as aimed at the byte-order test place.
   task automatic access(input logic wr, input logic sel);
      @(negedge clk);
      cs_n = ~sel;
      wr_n = ~wr;
      rd_n = wr;
      // Held past the two-flop sync and the take edge, since nothing acknowledges
      repeat (4) @(negedge clk);
      {cs_n, wr_n, rd_n} = 3'h7;
      repeat (4) @(negedge clk);
   endtask
endmodule

// file: bench/tb.sv
`timescale 1ns/1ps
module tb;
   import pmx_pkg::*;
   logic clk, rst_b, ee_drv, reset_in_n, pm_sleep, pme_event, pme_clear;
   logic mii_tx_en, mii_tx_clk, mii_rx_dv, mii_rx_clk, gp3, gp4;
   pmx_data_mode_t data_mode;
   pmx_clk_mode_t clk_mode;
   pmx_ee_ctl_t ee_ctl;
   pmx_wake_cfg_t wake_cfg;
   logic cs_n, wr_n, rd_n, pin_i, d_o, d_oe, sel_n, sclk, w_o, w_oe, ee_din;
   logic w_pend, w_req, sys_n, strap, strap_v, rd_seen, wr_ok, wr_drop;
   int fails = 0;
   int checks_done = 0;
   int n_ok = 0;
   int n_drop = 0;
   int n_wake = 0;

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Data pin wire: the design drive wins, else the board strap level
   assign pin_i = d_oe ? d_o : ee_drv;

   pmx_host pmx_host_i (.clk(clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n));

   pmx_top pmx_top_i (
      .clk(clk), .rst_b(rst_b), .eeprom_data_io_i(pin_i), .reset_in_n(reset_in_n),
      .chip_select_n(cs_n), .write_strobe_n(wr_n), .read_strobe_n(rd_n),
      .eeprom_data_io_o(d_o), .eeprom_data_io_oe(d_oe), .eeprom_select_n(sel_n),
      .eeprom_serial_clock(sclk), .wake_indicator_o(w_o), .wake_indicator_oe(w_oe),
      .mii_tx_en(mii_tx_en), .mii_tx_clk(mii_tx_clk), .mii_rx_dv(mii_rx_dv),
      .mii_rx_clk(mii_rx_clk), .data_mode(data_mode), .clk_mode(clk_mode),
      .gp_output_three(gp3), .gp_output_four(gp4), .ee_ctl(ee_ctl), .ee_din(ee_din),
      .pm_sleep(pm_sleep), .wake_cfg(wake_cfg), .pme_event(pme_event),
      .pme_clear(pme_clear), .wake_pending(w_pend), .wake_req(w_req),
      .sys_reset_n(sys_n), .bus_width_strap(strap), .strap_valid(strap_v),
      .host_read_seen(rd_seen), .host_write_ok(wr_ok), .host_write_drop(wr_drop)
   );

   // One-cycle pulses are counted at the edge that shows them
   always @(posedge clk)
   begin
      if (wr_ok === 1'b1) n_ok++;
      if (wr_drop === 1'b1) n_drop++;
      if (w_req === 1'b1) n_wake++;
   end

   task automatic results();
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic got, input logic exp, input string msg);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   // Bounded wait, since the stretch length is only known approximately
   task automatic wait_sys(input logic lvl);
      for (int i = 0; i < 400 && sys_n !== lvl; i++) @(negedge clk);
   endtask

   task automatic t_por();
      repeat (200) @(negedge clk);
      chk(sys_n, 1'b0, "reset stretch too short");
      chk(sel_n, 1'b1, "select active in reset");
      chk(d_oe, 1'b0, "data pin driven in reset");
      wait_sys(1'b1);
      chk(sys_n, 1'b1, "reset never released");
      chk(strap_v, 1'b1, "strap not valid");
      chk(strap, 1'b1, "strap high not 32-bit");
   endtask

   // Alternating source values tell every pin role apart from its neighbours
   task automatic t_mux();
      logic v;
      for (int p = 0; p < 2; p++)
         for (int m = 0; m < 16; m++)
         begin
            v = p[0];
            @(negedge clk);
            data_mode = pmx_data_mode_t'(m[1:0]);
            clk_mode = pmx_clk_mode_t'(m[3:2]);
            ee_ctl = '{cs: v, sclk: ~v, dout: v, doe: ~v};
            {gp3, gp4, mii_tx_en, mii_tx_clk, mii_rx_dv, mii_rx_clk, ee_drv} = {~v, v, v, ~v, ~v, v, v};
            repeat (5) @(negedge clk);
            chk(d_o, m[0] ? ~v : v, "data pin value");
            chk(d_oe, (m[1:0] == 0) ? ~v : 1'b1, "data pin enable");
            chk(sel_n, (m[3:0] == 0) ? ~v : 1'b1, "chip select");
            chk(sclk, m[2] ? v : ~v, "clock pin value");
            chk(ee_din, (m[1:0] == 0) ? v : 1'b0, "data pin input");
         end
      data_mode = PMX_D_EEPROM;
      clk_mode = PMX_C_EEPROM;
   endtask

   task automatic t_host();
      pmx_host_i.access(1'b1, 1'b1);
      chk(n_drop == 1 && n_ok == 0, 1'b1, "write before read acted");
      pmx_host_i.access(1'b0, 1'b1);
      chk(rd_seen, 1'b1, "read not seen");
      pmx_host_i.access(1'b1, 1'b1);
      pmx_host_i.access(1'b1, 1'b1);
      chk(n_ok == 2 && n_drop == 1, 1'b1, "armed writes lost");
      pm_sleep = 1'b1;
      pmx_host_i.access(1'b0, 1'b1);
      chk(rd_seen, 1'b0, "read armed while asleep");
      pmx_host_i.access(1'b1, 1'b0);
      chk(n_wake == 0, 1'b1, "woken without chip select");
      pmx_host_i.access(1'b1, 1'b1);
      chk(n_wake == 1 && n_ok == 2, 1'b1, "sleep write wake");
      @(negedge clk);
      pm_sleep = 1'b0;
      pmx_host_i.access(1'b1, 1'b1);
      chk(n_drop == 2 && n_ok == 2, 1'b1, "write after sleep acted");
   endtask

   task automatic t_wake();
      logic lvl;
      pm_sleep = 1'b1;
      for (int c = 0; c < 8; c++)
      begin
         @(negedge clk);
         wake_cfg = pmx_wake_cfg_t'(c[2:0]);
         pme_clear = 1'b1;
         @(negedge clk);
         pme_clear = 1'b0;
         pme_event = 1'b1;
         @(negedge clk);
         pme_event = 1'b0;
         repeat (2) @(negedge clk);
         lvl = c[2] ? c[1] : ~c[1];
         chk(w_pend, c[2], "wake pending");
         chk(w_oe, c[0] ? ~lvl : 1'b1, "wake pin enable");
         chk(w_o, c[0] ? 1'b0 : lvl, "wake pin level");
      end
      pme_clear = 1'b1;
      repeat (2) @(negedge clk);
      pme_clear = 1'b0;
      chk(w_pend, 1'b0, "pending not cleared");
      chk(n_wake == 1, 1'b1, "wake event woke device");
      pm_sleep = 1'b0;
   endtask

   task automatic t_rstin();
      @(negedge clk);
      reset_in_n = 1'b0;
      ee_drv = 1'b0;
      repeat (5) @(negedge clk);
      chk(sys_n, 1'b0, "reset pin ignored");
      chk(strap_v, 1'b0, "strap valid in reset");
      chk(sel_n, 1'b1, "select active in reset");
      reset_in_n = 1'b1;
      wait_sys(1'b1);
      chk(sys_n, 1'b1, "reset never released");
      chk(strap, 1'b0, "strap low not 16-bit");
   endtask

   initial
   begin
      {rst_b, ee_drv, reset_in_n, pm_sleep, pme_event, pme_clear} = 6'h18;
      {mii_tx_en, mii_tx_clk, mii_rx_dv, mii_rx_clk, gp3, gp4} = 6'h00;
      data_mode = PMX_D_EEPROM;
      clk_mode = PMX_C_EEPROM;
      ee_ctl = '0;
      wake_cfg = '0;
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      t_por();
      t_mux();
      t_host();
      t_wake();
      t_rstin();
      results();
   end

   // Whole run needs about 580 cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      $display("mismatch at %0t: run hung", $time);
      results();
   end
endmodule
